// File: logic/lintmc_pkg.sv
// Shared constants and types for the LIN transceiver mode control block
`default_nettype none
package lintmc_pkg;
  // Transceiver mode field encodings
  localparam logic [1:0] LIN_MODE_OFF = 2'h0;
  localparam logic [1:0] LIN_MODE_WAKE = 2'h1;
  localparam logic [1:0] LIN_MODE_RXONLY = 2'h2;
  localparam logic [1:0] LIN_MODE_NORMAL = 2'h3;
  // Chip operating mode encodings
  localparam logic [2:0] CHIP_NORMAL = 3'h0;
  localparam logic [2:0] CHIP_STOP = 3'h1;
  localparam logic [2:0] CHIP_SLEEP = 3'h2;
  localparam logic [2:0] CHIP_RESTART = 3'h3;
  localparam logic [2:0] CHIP_FAILSAFE = 3'h4;
  // Timing figures in microseconds and derived counts at 40 MHz
  localparam int CLK_MHZ = 40;
  localparam int T_EN_US = 10;
  localparam int EN_CYCLES = T_EN_US * CLK_MHZ;
  localparam int T_TXD_TO_US = 2000;
  localparam int TXD_TO_CYCLES = T_TXD_TO_US * CLK_MHZ;
  typedef enum logic [1:0] {LINTMC_OFF, LINTMC_WAKE, LINTMC_RXO,
    LINTMC_NORM} lintmc_mode_t;
endpackage
`default_nettype wire

// File: logic/lintmc_guard_if.sv
// Signals between mode control and the transmit guard
`default_nettype none
interface lintmc_guard_if;
  logic start;
  logic active;
  logic tx_dom;
  logic drive;
  logic fail_evt;
  modport ctrl (output start, output active, output tx_dom,
    input drive, input fail_evt);
  modport guard (input start, input active, input tx_dom,
    output drive, output fail_evt);
endinterface
`default_nettype wire

// File: logic/lintmc_tx_guard.sv
// Enabling-time and dominant time-out guard for the LIN transmit path
`default_nettype none
module lintmc_tx_guard
  import lintmc_pkg::*;
#(
  parameter int EN_CNT = EN_CYCLES,
  parameter int TO_CNT = TXD_TO_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Control side
  lintmc_guard_if.guard g
);
  logic [12:0] en_cnt;
  logic [12:0] next_en_cnt;
  logic [22:0] to_cnt;
  logic [22:0] next_to_cnt;
  logic armed;
  logic next_armed;
  logic blocked;
  logic next_blocked;
  logic tx_on;
  logic next_tx_on;
  logic timed_out;
  logic next_timed_out;

  always_comb begin
    next_en_cnt = en_cnt;
    next_armed = armed;
    next_blocked = blocked;
    next_to_cnt = to_cnt;
    next_timed_out = timed_out;
    if (g.start || !g.active) begin
      next_en_cnt = '0;
      next_armed = 1'b0;
      next_blocked = 1'b0;
    end else if (!armed) begin
      if (en_cnt >= 13'(EN_CNT - 1))
        next_armed = 1'b1;
      else
        next_en_cnt = en_cnt + 13'h1;
      if (g.tx_dom)
        next_blocked = 1'b1;
    end else if (!g.tx_dom) begin
      next_blocked = 1'b0;
    end
    if (!g.tx_dom || !g.active) begin
      next_to_cnt = '0;
      next_timed_out = 1'b0;
    end else if (to_cnt >= 23'(TO_CNT - 1)) begin
      next_timed_out = 1'b1;
    end else begin
      next_to_cnt = to_cnt + 23'h1;
    end
    next_tx_on = g.active && armed && !next_blocked && g.tx_dom &&
      !next_timed_out;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      en_cnt <= '0;
      armed <= 1'b0;
      blocked <= 1'b0;
      to_cnt <= '0;
      timed_out <= 1'b0;
      tx_on <= 1'b0;
    end else begin
      en_cnt <= next_en_cnt;
      armed <= next_armed;
      blocked <= next_blocked;
      to_cnt <= next_to_cnt;
      timed_out <= next_timed_out;
      tx_on <= next_tx_on;
    end
  end

  assign g.drive = tx_on;
  assign g.fail_evt = next_timed_out && !timed_out;

  AST_EARLY_DOM_BLOCKED: assert property (@(posedge mclk)
    disable iff (srst)
    (g.active && !armed) |=> !g.drive)
    else $error("Driver active before enabling time");
  AST_TIMEOUT_STOPS: assert property (@(posedge mclk)
    disable iff (srst)
    timed_out |-> !g.drive)
    else $error("Driver active after dominant time-out");
endmodule
`default_nettype wire

// File: logic/lintmc_top.sv
// LIN transceiver mode control and data path
//
// Operation
// - The transceiver starts off after reset and off is allowed in every chip mode, silencing the bus.
// - In off mode bus wake activity is ignored.
// - The mode comes from a mode field written over SPI.
// - Normal mode is entered only in chip normal mode and stays usable in chip normal and stop.
// - In normal mode a low transmit input drives a dominant bus, a high one leaves it recessive.
// - A dominant input during the enabling time never reaches the bus; only the next fresh dominant bit does.
// - In normal and receive-only modes the receive output is low on a dominant bus and high otherwise.
// - In receive-only mode the driver stays off while reception continues.
// - Receive-only mode is entered by SPI only in chip normal or stop mode.
// - Wake-capable mode is code 01; after a bus wake the field keeps 01 and receive stays low until a non-01 write or entry to chip stop, sleep or fail-safe.
// - A transmit input dominant past the time-out disables the driver until recessive and sets the failure flag until fail_clr.
`default_nettype none
module lintmc_top
  import lintmc_pkg::*;
#(
  parameter int EN_CNT = EN_CYCLES,
  parameter int TO_CNT = TXD_TO_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Register side mode request
  input wire logic mode_wr,
  input wire logic [1:0] mode_wdata,
  output logic [1:0] lin_mode_field,
  input wire logic [2:0] chip_mode,
  input wire logic fail_clr,
  output logic lin_failure_flag,
  output logic wake_evt,
  // Microcontroller pins
  input wire logic lin_transmit_input,
  output logic lin_receive_output,
  // Bus stage
  input wire logic bus_dominant,
  input wire logic bus_wake,
  output logic bus_drive_dom
);
  lintmc_guard_if gif ();
  lintmc_mode_t mode;
  lintmc_mode_t next_mode;
  logic woken;
  logic next_woken;
  logic fail;
  logic next_fail;
  logic rxd;
  logic next_rxd;
  logic wk;
  logic next_wk;
  logic [2:0] prev_chip;
  logic next_active;

  function automatic logic chip_run(input logic [2:0] cm);
    return (cm == CHIP_NORMAL) || (cm == CHIP_STOP);
  endfunction

  always_comb begin
    next_mode = mode;
    next_woken = woken;
    next_wk = 1'b0;
    if (mode_wr) begin
      case (mode_wdata)
        LIN_MODE_OFF: next_mode = LINTMC_OFF;
        LIN_MODE_WAKE: next_mode = LINTMC_WAKE;
        LIN_MODE_RXONLY:
          if (chip_run(chip_mode)) next_mode = LINTMC_RXO;
        LIN_MODE_NORMAL:
          if (chip_mode == CHIP_NORMAL) next_mode = LINTMC_NORM;
        default: next_mode = mode;
      endcase
      // Mode toggle rearms wake
      if (next_mode != mode || mode_wdata != LIN_MODE_WAKE)
        next_woken = 1'b0;
    end
    // normal and receive-only need normal or stop
    if (!chip_run(chip_mode) && next_mode != LINTMC_OFF)
      next_mode = LINTMC_WAKE;
    // Rearm wake capability when chip enters a low-power mode
    if (chip_mode != prev_chip && chip_mode != CHIP_NORMAL &&
        chip_mode != CHIP_RESTART)
      next_woken = 1'b0;
    // wake only counts in wake-capable mode
    if (mode == LINTMC_WAKE && next_mode == LINTMC_WAKE && bus_wake &&
        !woken) begin
      next_woken = 1'b1;
      next_wk = 1'b1;
    end
    if (next_mode != LINTMC_WAKE)
      next_woken = 1'b0;
    next_active = (next_mode == LINTMC_NORM);
    next_fail = gif.fail_evt ? 1'b1 : (fail_clr ? 1'b0 : fail);
    case (next_mode)
      LINTMC_NORM, LINTMC_RXO: next_rxd = !bus_dominant;
      LINTMC_WAKE: next_rxd = !next_woken;
      default: next_rxd = 1'b1;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      mode <= LINTMC_OFF;
      woken <= 1'b0;
      fail <= 1'b0;
      rxd <= 1'b1;
      wk <= 1'b0;
      prev_chip <= CHIP_NORMAL;
    end else begin
      mode <= next_mode;
      woken <= next_woken;
      fail <= next_fail;
      rxd <= next_rxd;
      wk <= next_wk;
      prev_chip <= chip_mode;
    end
  end

  assign gif.start = next_active && (mode != LINTMC_NORM);
  assign gif.active = next_active;
  assign gif.tx_dom = !lin_transmit_input;

  lintmc_tx_guard #(.EN_CNT(EN_CNT), .TO_CNT(TO_CNT)) u_guard (
    .mclk(mclk),
    .srst(srst),
    .g(gif.guard)
  );

  assign bus_drive_dom = gif.drive && (mode == LINTMC_NORM);
  assign lin_mode_field = mode;
  assign lin_failure_flag = fail;
  assign lin_receive_output = rxd;
  assign wake_evt = wk;

  AST_OFF_SILENT: assert property (@(posedge mclk)
    disable iff (srst)
    (mode == LINTMC_OFF) |-> (!bus_drive_dom && lin_receive_output))
    else $error("Off mode not silent");
  AST_OFF_NO_WAKE: assert property (@(posedge mclk)
    disable iff (srst)
    (mode == LINTMC_OFF) |=> !wake_evt)
    else $error("Wake reported in off mode");
  AST_MODE_WRITE: assert property (@(posedge mclk)
    disable iff (srst)
    (mode_wr && mode_wdata == LIN_MODE_OFF) |=> (lin_mode_field == 2'h0))
    else $error("Off write not taken");
  AST_NORM_GATE: assert property (@(posedge mclk)
    disable iff (srst)
    (mode != LINTMC_NORM && chip_mode != CHIP_NORMAL) |=>
      (mode != LINTMC_NORM))
    else $error("Normal mode entered outside chip normal");
  AST_TX_POLARITY: assert property (@(posedge mclk)
    disable iff (srst)
    bus_drive_dom |-> !$past(lin_transmit_input))
    else $error("Dominant driven from high input");
  AST_RX_FOLLOW: assert property (@(posedge mclk)
    disable iff (srst)
    (mode == LINTMC_RXO && $past(mode) == LINTMC_RXO) |->
      (lin_receive_output == !$past(bus_dominant)))
    else $error("Receive output does not follow bus");
  AST_RXO_NODRIVE: assert property (@(posedge mclk)
    disable iff (srst)
    (mode == LINTMC_RXO) |-> !bus_drive_dom)
    else $error("Driver active in receive-only");
  AST_RXO_GATE: assert property (@(posedge mclk)
    disable iff (srst)
    (mode_wr && mode_wdata == LIN_MODE_RXONLY && !chip_run(chip_mode) &&
     mode == LINTMC_OFF) |=> (mode == LINTMC_OFF))
    else $error("Receive-only entered in wrong chip mode");
  AST_LOWPWR_MODES: assert property (@(posedge mclk)
    disable iff (srst)
    !chip_run(chip_mode) |=>
      (mode == LINTMC_OFF || mode == LINTMC_WAKE))
    else $error("Active transceiver mode in low-power chip mode");
  AST_WAKE_HOLD: assert property (@(posedge mclk)
    disable iff (srst)
    (woken && !mode_wr) |=>
      (lin_mode_field == 2'h1 && !lin_receive_output))
    else $error("Wake indication not held");
  AST_FAIL_STICKY: assert property (@(posedge mclk)
    disable iff (srst)
    (fail && !fail_clr) |=> fail)
    else $error("Failure flag lost");
  AST_FAIL_SET: assert property (@(posedge mclk)
    disable iff (srst)
    gif.fail_evt |=> lin_failure_flag)
    else $error("Failure flag not set on time-out");
  AST_REFUSED_KEEP: assert property (@(posedge mclk)
    disable iff (srst)
    (mode_wr && mode_wdata == LIN_MODE_NORMAL && chip_mode == CHIP_STOP &&
     mode == LINTMC_RXO) |=> (mode == LINTMC_RXO))
    else $error("Refused request changed mode");

  COV_NORMAL_TX: cover property (@(posedge mclk) disable iff (srst)
    bus_drive_dom);
  COV_WAKE: cover property (@(posedge mclk) disable iff (srst) wake_evt);
  COV_FAIL: cover property (@(posedge mclk) disable iff (srst)
    $rose(lin_failure_flag));
  COV_RXO: cover property (@(posedge mclk) disable iff (srst)
    mode == LINTMC_RXO);
endmodule
`default_nettype wire

// File: dv/lintmc_bus_model.sv
// Behavioural LIN bus with a remote node and a wake request passed straight through
`default_nettype none
module lintmc_bus_model (
  // Local driver and remote node
  input wire logic drive_dom,
  input wire logic remote_dom,
  input wire logic wake_req,
  // Receiver side
  output logic bus_dominant,
  output logic bus_wake
);
  timeunit 1ns;
  timeprecision 1ps;
  // Any node pulling low wins; the pull-up makes an idle bus recessive
  assign bus_dominant = drive_dom | remote_dom;
  assign bus_wake = wake_req;
endmodule
`default_nettype wire

// File: dv/tb_lin_transceiver_mode_control.sv
// Self-checking bench for the LIN transceiver mode control block
`default_nettype none
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin \
  errors++; $display("MISMATCH %s exp=%h got=%h", nm, ex, gt); end end
module tb_lin_transceiver_mode_control;
  import lintmc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int EN_T = 8;
  localparam int TO_T = 20;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic mode_wr = 1'b0;
  logic [1:0] mode_wdata = 2'h0;
  logic [2:0] chip_mode = CHIP_NORMAL;
  logic fail_clr = 1'b0;
  logic txd = 1'b1;
  logic remote_dom = 1'b0;
  logic wake_req = 1'b0;
  logic [1:0] field;
  logic flag, wake_evt, rxd, bus_dom, bus_wake, drive;
  int errors = 0;
  int check_count = 0;
  always #12.5 mclk = ~mclk;
  lintmc_top #(.EN_CNT(EN_T), .TO_CNT(TO_T)) i_dut (.mclk(mclk),
    .srst(srst), .mode_wr(mode_wr), .mode_wdata(mode_wdata),
    .lin_mode_field(field), .chip_mode(chip_mode), .fail_clr(fail_clr),
    .lin_failure_flag(flag), .wake_evt(wake_evt),
    .lin_transmit_input(txd), .lin_receive_output(rxd),
    .bus_dominant(bus_dom), .bus_wake(bus_wake), .bus_drive_dom(drive));
  lintmc_bus_model i_bus (.drive_dom(drive), .remote_dom(remote_dom),
    .wake_req(wake_req), .bus_dominant(bus_dom), .bus_wake(bus_wake));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge mclk);
  endtask
  // Mode write, one-cycle strobe; field settled one cycle after
  task automatic wr(logic [1:0] m, logic [2:0] c);
    chip_mode = c;
    mode_wr = 1'b1;
    mode_wdata = m;
    cyc(1);
    mode_wr = 1'b0;
    cyc(2);
  endtask
  // Bounded wait: 0 drive, 1 receive output, 2 wake pulse
  task automatic wait_out(int which, logic ex);
    logic v;
    for (int i = 0; i < 10; i++) begin
      v = (which == 0) ? drive : (which == 1) ? rxd : wake_evt;
      if (v === ex) begin
        check_count++;
        return;
      end
      cyc(1);
    end
    errors++;
    $display("MISMATCH wait%0d exp=%h got=%h", which, ex, v);
    finish_test();
  endtask
  task automatic t_off();
    txd = 1'b0;
    wake_req = 1'b1;
    cyc(4);
    `CHK("field", LIN_MODE_OFF, field)
    `CHK("drive", 1'b0, drive)
    `CHK("rxd", 1'b1, rxd)
    `CHK("wake", 1'b0, wake_evt)
    wake_req = 1'b0;
    txd = 1'b1;
    $display("test off done");
  endtask
  task automatic t_refuse();
    wr(LIN_MODE_NORMAL, CHIP_STOP);
    `CHK("field", LIN_MODE_OFF, field)
    wr(LIN_MODE_RXONLY, CHIP_STOP);
    `CHK("field", LIN_MODE_RXONLY, field)
    wr(LIN_MODE_NORMAL, CHIP_STOP);
    `CHK("field", LIN_MODE_RXONLY, field)
    $display("test refuse done");
  endtask
  task automatic t_rxonly();
    txd = 1'b0;
    cyc(4);
    `CHK("drive", 1'b0, drive)
    remote_dom = 1'b1;
    wait_out(1, 1'b0);
    remote_dom = 1'b0;
    wait_out(1, 1'b1);
    txd = 1'b1;
    $display("test rxonly done");
  endtask
  task automatic t_enable();
    txd = 1'b0;
    wr(LIN_MODE_NORMAL, CHIP_NORMAL);
    `CHK("field", LIN_MODE_NORMAL, field)
    for (int i = 0; i < EN_T + 6; i++) begin
      `CHK("drive", 1'b0, drive)
      cyc(1);
    end
    // controller releases, then a fresh dominant bit
    txd = 1'b1;
    cyc(2);
    `CHK("drive", 1'b0, drive)
    txd = 1'b0;
    wait_out(0, 1'b1);
    wait_out(1, 1'b0);
    txd = 1'b1;
    wait_out(0, 1'b0);
    chip_mode = CHIP_STOP;
    cyc(2);
    `CHK("field", LIN_MODE_NORMAL, field)
    txd = 1'b0;
    wait_out(0, 1'b1);
    txd = 1'b1;
    cyc(2);
    $display("test enable done");
  endtask
  task automatic t_timeout();
    txd = 1'b0;
    cyc(TO_T + 6);
    `CHK("drive", 1'b0, drive)
    `CHK("flag", 1'b1, flag)
    `CHK("field", LIN_MODE_NORMAL, field)
    txd = 1'b1;
    fail_clr = 1'b1;
    cyc(1);
    fail_clr = 1'b0;
    cyc(2);
    `CHK("flag", 1'b0, flag)
    txd = 1'b0;
    wait_out(0, 1'b1);
    txd = 1'b1;
    wr(LIN_MODE_OFF, CHIP_STOP);
    txd = 1'b0;
    cyc(3);
    `CHK("field", LIN_MODE_OFF, field)
    `CHK("drive", 1'b0, drive)
    txd = 1'b1;
    $display("test timeout done");
  endtask
  task automatic t_wake();
    wr(LIN_MODE_WAKE, CHIP_NORMAL);
    `CHK("rxd", 1'b1, rxd)
    wake_req = 1'b1;
    wait_out(2, 1'b1);
    wake_req = 1'b0;
    cyc(6);
    `CHK("field", LIN_MODE_WAKE, field)
    `CHK("rxd", 1'b0, rxd)
    wr(LIN_MODE_OFF, CHIP_NORMAL);
    `CHK("rxd", 1'b1, rxd)
    $display("test wake done");
  endtask
  // Sleep, restart and fail-safe chip modes allow only off or wake
  task automatic t_lowpower();
    wr(LIN_MODE_RXONLY, CHIP_SLEEP);
    `CHK("field", LIN_MODE_OFF, field)
    wr(LIN_MODE_RXONLY, CHIP_NORMAL);
    `CHK("field", LIN_MODE_RXONLY, field)
    chip_mode = CHIP_SLEEP;
    cyc(2);
    `CHK("field", LIN_MODE_WAKE, field)
    wr(LIN_MODE_NORMAL, CHIP_RESTART);
    `CHK("field", LIN_MODE_WAKE, field)
    chip_mode = CHIP_FAILSAFE;
    cyc(1);
    wake_req = 1'b1;
    wait_out(2, 1'b1);
    wake_req = 1'b0;
    cyc(2);
    `CHK("rxd", 1'b0, rxd)
    wr(LIN_MODE_OFF, CHIP_FAILSAFE);
    `CHK("field", LIN_MODE_OFF, field)
    chip_mode = CHIP_NORMAL;
    $display("test lowpower done");
  endtask
  initial begin
    cyc(12);
    srst = 1'b0;
    t_off();
    t_refuse();
    t_rxonly();
    t_enable();
    t_timeout();
    t_wake();
    t_lowpower();
    finish_test();
  end
endmodule
`default_nettype wire
